// ---- core/dlc_pkg.sv ----
// Shared constants of the DAC load and clear control block.
// Assumes a 200 MHz system clock and an eight-channel, 16-bit DAC core.
package dlc_pkg;

    // Channel count, code width and the all-channels selector.
    localparam int NUM_CH = 8;
    localparam int CODE_W = 16;
    localparam logic [3:0] CHAN_ALL = 4'hf;

    // Upper six slave address bits; the value is arbitrary.
    localparam logic [5:0] SLAVE_ADDR_HI = 6'h2a;

    // Layout of the 32-bit shift word: address, R/W, command, channel, code.
    localparam int SH_W = 32;
    localparam int SH_ADDR_LSB = 25;
    localparam int SH_RW_BIT = 24;
    localparam int SH_CMD_LSB = 20;
    localparam int SH_CHAN_LSB = 16;
    localparam int SH_CODE_LSB = 0;
    localparam logic [1:0] LAST_BYTE = 2'h3;

    // Command codes carried in the command nibble.
    localparam logic [3:0] CMD_WRITE_IN = 4'h0;
    localparam logic [3:0] CMD_UPDATE = 4'h1;
    localparam logic [3:0] CMD_WRITE_UPD = 4'h3;
    localparam logic [3:0] CMD_CLR_CODE = 4'h5;
    localparam logic [3:0] CMD_REF_CTL = 4'h8;

    // Clear-code settings and the codes they load.
    localparam logic [1:0] CLR_ZERO = 2'h0;
    localparam logic [1:0] CLR_MID = 2'h1;
    localparam logic [1:0] CLR_FULL = 2'h2;
    localparam logic [15:0] CODE_ZERO = 16'h0000;
    localparam logic [15:0] CODE_MID = 16'h8000;
    localparam logic [15:0] CODE_FULL = 16'hffff;

    // Reset values of the control state.
    localparam logic [1:0] RST_CLR_CODE = CLR_ZERO;
    localparam logic RST_INT_REF = 1'b0;

endpackage : dlc_pkg

// ---- core/dlc_wr_if.sv ----
// Carrier for completed serial write words between receiver and register logic.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface dlc_wr_if;
    logic valid;
    logic [3:0] cmd;
    logic [3:0] chan;
    logic [15:0] code;

    modport src (output valid, output cmd, output chan, output code);
    modport dst (input valid, input cmd, input chan, input code);
endinterface : dlc_wr_if

// ---- core/dlc_i2c_rx.sv ----
// Two-wire serial receiver that fills the 32-bit shift word and acknowledges bytes.
// Assumes raw bus pins; both are synchronised here before use.
`timescale 1ns/1ps
module dlc_i2c_rx (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sclPin,
    input wire logic sdaPin,
    input wire logic addrBit,
    output logic sdaPullFf,
    dlc_wr_if.src wr
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RECV = 4'b0010,
        ST_ACK = 4'b0100,
        ST_HOLD = 4'b1000
    } dlc_rx_state_t;

    dlc_rx_state_t stateFf;
    logic sclS1Ff, sclS2Ff, sclPrevFf;
    logic sdaS1Ff, sdaS2Ff, sdaPrevFf;
    logic [2:0] bitCntFf;
    logic [1:0] byteCntFf;
    logic byteDoneFf;
    logic [dlc_pkg::SH_W-1:0] shiftFf;
    logic sclRise, sclFall, startCond, stopCond, addrHit;

    // Two-flop synchronisers; only the second stage feeds the detectors.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            {sclS1Ff, sclS2Ff, sclPrevFf} <= 3'h7;
            {sdaS1Ff, sdaS2Ff, sdaPrevFf} <= 3'h7;
        end
        else
        begin
            {sclS1Ff, sclS2Ff, sclPrevFf} <= {sclPin, sclS1Ff, sclS2Ff};
            {sdaS1Ff, sdaS2Ff, sdaPrevFf} <= {sdaPin, sdaS1Ff, sdaS2Ff};
        end
    end

    // Bus events seen on the synchronised lines.
    assign sclRise = sclS2Ff & ~sclPrevFf;
    assign sclFall = ~sclS2Ff & sclPrevFf;
    assign startCond = sclS2Ff & sclPrevFf & sdaPrevFf & ~sdaS2Ff;
    assign stopCond = sclS2Ff & sclPrevFf & ~sdaPrevFf & sdaS2Ff;
    // Reads are refused: only a write to our own address is acknowledged.
    assign addrHit = (shiftFf[7:1] == {dlc_pkg::SLAVE_ADDR_HI, addrBit}) && !shiftFf[0];

    // Byte framing, acknowledge and word hand-off.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            stateFf <= ST_IDLE;
            bitCntFf <= 3'h0;
            byteCntFf <= 2'h0;
            byteDoneFf <= 1'b0;
            shiftFf <= '0;
            sdaPullFf <= 1'b0;
            wr.valid <= 1'b0;
        end
        else
        begin
            wr.valid <= 1'b0;
            if (startCond)
            begin
                stateFf <= ST_RECV;
                bitCntFf <= 3'h0;
                byteCntFf <= 2'h0;
                byteDoneFf <= 1'b0;
                sdaPullFf <= 1'b0;
            end
            else if (stopCond)
            begin
                stateFf <= ST_IDLE;
                sdaPullFf <= 1'b0;
            end
            else
            begin
                case (stateFf)
                    ST_RECV:
                    begin
                        if (sclRise)
                        begin
                            shiftFf <= {shiftFf[dlc_pkg::SH_W-2:0], sdaS2Ff};
                            bitCntFf <= bitCntFf + 3'h1;
                            byteDoneFf <= (bitCntFf == 3'h7);
                        end
                        else if (sclFall && byteDoneFf)
                        begin
                            byteDoneFf <= 1'b0;
                            if (byteCntFf != 2'h0 || addrHit)
                            begin
                                sdaPullFf <= 1'b1; // Pull low only, never drive high.
                                stateFf <= ST_ACK;
                            end
                            else
                            begin
                                stateFf <= ST_HOLD;
                            end
                        end
                    end
                    ST_ACK:
                    begin
                        if (sclFall)
                        begin
                            sdaPullFf <= 1'b0;
                            stateFf <= ST_RECV;
                            // A word is complete at the ninth falling clock of its last byte.
                            if (byteCntFf == dlc_pkg::LAST_BYTE)
                            begin
                                wr.valid <= 1'b1;
                                wr.cmd <= shiftFf[dlc_pkg::SH_CMD_LSB +: 4];
                                wr.chan <= shiftFf[dlc_pkg::SH_CHAN_LSB +: 4];
                                wr.code <= shiftFf[dlc_pkg::SH_CODE_LSB +: dlc_pkg::CODE_W];
                                byteCntFf <= 2'h1; // Further triplets in the frame are new words.
                            end
                            else
                            begin
                                byteCntFf <= byteCntFf + 2'h1;
                            end
                        end
                    end
                    ST_HOLD:
                    begin
                        stateFf <= ST_HOLD; // Not addressed: wait for the next start or stop.
                    end
                    default:
                    begin
                        stateFf <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule : dlc_i2c_rx

// ---- core/dlc_top.sv ----
// Load strobe, clear and serial-write control for an eight-channel DAC.
// Assumes asynchronous pins from the board; all pass two flip-flops here.
// Notes on behaviour
// - Load strobe pulse moves pending data to DACs.
// - Address pin supplies slave address LSB.
// - Clear acts on falling edge, no bus clock.
// - Load pulses ignored while clear is low.
// - Clear loads input and DAC with clear code.
// - Clear code resets to zero scale.
// - Serial data fills 32-bit shift register.
// - Data line is open drain, pull low only.
// - Reference pin is input until internal reference.
`timescale 1ns/1ps
module dlc_top (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sclPin,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic load_strobe_n,
    input wire logic async_clear_n,
    input wire logic addr_select_pin,
    output logic [dlc_pkg::NUM_CH-1:0][dlc_pkg::CODE_W-1:0] dacCode,
    output logic [dlc_pkg::NUM_CH-1:0][dlc_pkg::CODE_W-1:0] inputCode,
    output logic [dlc_pkg::NUM_CH-1:0] pendingFf,
    output logic [1:0] clrCodeFf,
    output logic refOutEnFf
);
    dlc_wr_if wr ();

    logic ldS1Ff, ldS2Ff, ldPrevFf;
    logic clrS1Ff, clrS2Ff, clrPrevFf;
    logic adrS1Ff, adrS2Ff;
    logic sdaOutFf;
    logic [dlc_pkg::NUM_CH-1:0][dlc_pkg::CODE_W-1:0] dacRegFf;
    logic [dlc_pkg::NUM_CH-1:0][dlc_pkg::CODE_W-1:0] inRegFf;
    logic [dlc_pkg::CODE_W-1:0] clrValue;
    logic ldFall, clrFall, clrHigh, ldHeldLow, isWrite, isUpdate;
    logic [dlc_pkg::NUM_CH-1:0] chanHit;

    // Receiver for the two-wire link; its pull-low flop drives the enable directly.
    dlc_i2c_rx u_rx (
        .clock(clock),
        .rst_n(rst_n),
        .sclPin(sclPin),
        .sdaPin(sdaIn),
        .addrBit(adrS2Ff),
        .sdaPullFf(sdaOe),
        .wr(wr)
    );

    // Pin synchronisers. The clear pin is sampled, so a low pulse must span a clock.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            {ldS1Ff, ldS2Ff, ldPrevFf} <= 3'h7;
            {clrS1Ff, clrS2Ff, clrPrevFf} <= 3'h7;
            {adrS1Ff, adrS2Ff} <= 2'h0;
        end
        else
        begin
            {ldS1Ff, ldS2Ff, ldPrevFf} <= {load_strobe_n, ldS1Ff, ldS2Ff};
            {clrS1Ff, clrS2Ff, clrPrevFf} <= {async_clear_n, clrS1Ff, clrS2Ff};
            {adrS1Ff, adrS2Ff} <= {addr_select_pin, adrS1Ff};
        end
    end

    // Decoded strobes and commands.
    assign ldFall = ldPrevFf & ~ldS2Ff;
    assign clrFall = clrPrevFf & ~clrS2Ff; // Edge, not level, starts a clear.
    assign clrHigh = clrS2Ff;
    assign ldHeldLow = ~ldS2Ff & clrHigh; // A strobe tied low is a legal mode.
    assign isWrite = wr.valid && (wr.cmd == dlc_pkg::CMD_WRITE_IN || wr.cmd == dlc_pkg::CMD_WRITE_UPD);
    assign isUpdate = wr.valid && wr.cmd == dlc_pkg::CMD_UPDATE;

    // Code loaded by a clear; the unused setting falls back to zero scale.
    always_comb
    begin
        case (clrCodeFf)
            dlc_pkg::CLR_MID: clrValue = dlc_pkg::CODE_MID;
            dlc_pkg::CLR_FULL: clrValue = dlc_pkg::CODE_FULL;
            default: clrValue = dlc_pkg::CODE_ZERO;
        endcase
    end

    // Clear-code setting and reference pin direction, both set by serial command.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            clrCodeFf <= dlc_pkg::RST_CLR_CODE;
            refOutEnFf <= dlc_pkg::RST_INT_REF; // Pin starts as a reference input.
        end
        else if (wr.valid)
        begin
            if (wr.cmd == dlc_pkg::CMD_CLR_CODE)
            begin
                clrCodeFf <= wr.code[1:0];
            end
            if (wr.cmd == dlc_pkg::CMD_REF_CTL)
            begin
                refOutEnFf <= wr.code[0]; // Output only with the internal reference.
            end
        end
    end

    // Channels named by the finished word; the all-channels selector hits every one.
    // Unused channel numbers hit nothing, so such a write is dropped quietly.
    always_comb
    begin
        for (int i = 0; i < dlc_pkg::NUM_CH; i++)
        begin
            chanHit[i] = (wr.chan == dlc_pkg::CHAN_ALL) || (wr.chan == 4'(i));
        end
    end

    // Input registers. A clear outranks a write landing in the same cycle,
    // so the clear value is what software finds afterwards.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            inRegFf <= '0;
        end
        else
        begin
            for (int i = 0; i < dlc_pkg::NUM_CH; i++)
            begin
                if (clrFall)
                begin
                    inRegFf[i] <= clrValue;
                end
                else if (isWrite && chanHit[i])
                begin
                    inRegFf[i] <= wr.code;
                end
            end
        end
    end

    // DAC registers. A write that updates at once beats a load edge in the same cycle,
    // so the newest code is the one that reaches the output.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            dacRegFf <= '0;
        end
        else
        begin
            for (int i = 0; i < dlc_pkg::NUM_CH; i++)
            begin
                if (clrFall)
                begin
                    dacRegFf[i] <= clrValue;
                end
                else if (isWrite && chanHit[i] && (ldHeldLow || wr.cmd == dlc_pkg::CMD_WRITE_UPD))
                begin
                    dacRegFf[i] <= wr.code;
                end
                else if (isUpdate && chanHit[i])
                begin
                    dacRegFf[i] <= inRegFf[i];
                end
                else if (ldFall && clrHigh && pendingFf[i]) // Pulses are dropped while clear is low.
                begin
                    dacRegFf[i] <= inRegFf[i]; // All pending channels move together.
                end
            end
        end
    end

    // Pending flags. A write in the cycle of a load edge sees the strobe low as held low,
    // so it reaches the DAC at once and the flag is left clear.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pendingFf <= '0;
        end
        else
        begin
            for (int i = 0; i < dlc_pkg::NUM_CH; i++)
            begin
                if (clrFall)
                begin
                    pendingFf[i] <= 1'b0;
                end
                else if (isWrite && chanHit[i])
                begin
                    pendingFf[i] <= !(ldHeldLow || wr.cmd == dlc_pkg::CMD_WRITE_UPD);
                end
                else if ((isUpdate && chanHit[i]) || (ldFall && clrHigh))
                begin
                    pendingFf[i] <= 1'b0;
                end
            end
        end
    end

    // Data line level is always low; only the enable toggles, so it never drives high.
    // Reset gives it a defined level before the first bus activity.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            sdaOutFf <= 1'b0;
        end
        else
        begin
            sdaOutFf <= 1'b0;
        end
    end

    assign sdaOut = sdaOutFf;
    assign dacCode = dacRegFf;
    assign inputCode = inRegFf;
endmodule : dlc_top

// ---- tb/dlc_monitor.sv ----
// Checker for load, clear and acknowledge behaviour at the top ports.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module dlc_monitor (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sclPin,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic load_strobe_n,
    input wire logic async_clear_n,
    input wire logic addr_select_pin,
    input wire logic [dlc_pkg::NUM_CH-1:0][dlc_pkg::CODE_W-1:0] dacCode,
    input wire logic [dlc_pkg::NUM_CH-1:0][dlc_pkg::CODE_W-1:0] inputCode,
    input wire logic [dlc_pkg::NUM_CH-1:0] pendingFf,
    input wire logic [1:0] clrCodeFf,
    input wire logic refOutEnFf
);
    logic [15:0] clrVal;
    logic [3:0] clrLowCnt;
    logic [3:0] clrHighCnt;
    logic [3:0] ldLowCnt;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // Code a clear must load; setting 3 falls back to zero scale.
    assign clrVal = (clrCodeFf == dlc_pkg::CLR_MID) ? dlc_pkg::CODE_MID :
        (clrCodeFf == dlc_pkg::CLR_FULL) ? dlc_pkg::CODE_FULL : dlc_pkg::CODE_ZERO;
    // Saturating level counters, so pin edges near a level change are not judged.
    always_ff @(posedge clock)
        clrLowCnt <= (!rst_n || async_clear_n) ? 4'h0 : clrLowCnt + {3'h0, clrLowCnt != 4'hf};
    always_ff @(posedge clock)
        clrHighCnt <= (!rst_n || !async_clear_n) ? 4'h0 : clrHighCnt + {3'h0, clrHighCnt != 4'hf};
    always_ff @(posedge clock)
        ldLowCnt <= (!rst_n || load_strobe_n) ? 4'h0 : ldLowCnt + {3'h0, ldLowCnt != 4'hf};

    a_sda_low_only: assert property (sdaOut == 1'b0)
        else $error("data line driven high");
    a_ack_scl_low: assert property ($changed(sdaOe) |-> !sclPin)
        else $error("acknowledge moved while bus clock high");
    a_clear_loads: assert property ($fell(async_clear_n) |-> ##[3:5]
        (dacCode == {dlc_pkg::NUM_CH{clrVal}} && inputCode == {dlc_pkg::NUM_CH{clrVal}}))
        else $error("clear value not loaded");
    a_clear_edge_pend: assert property ($fell(async_clear_n) |-> ##[3:5] pendingFf == '0)
        else $error("clear edge left data pending");
    a_load_ignored: assert property (clrLowCnt > 4'h8 && $fell(load_strobe_n) |-> ##1 $stable(dacCode) [*6])
        else $error("load acted during clear");
    a_load_moves: assert property (clrHighCnt > 4'h8 && $fell(load_strobe_n) |-> ##[2:5]
        (pendingFf == '0 && dacCode == inputCode))
        else $error("load did not move pending data");
    a_held_low_pass: assert property (clrHighCnt > 4'h8 && ldLowCnt > 4'h8 |-> pendingFf == '0)
        else $error("data pending while load held low");
    a_clr_code_rst: assert property ($rose(rst_n) |-> clrCodeFf == dlc_pkg::RST_CLR_CODE)
        else $error("clear code not zero scale after reset");
    a_ref_in_rst: assert property ($rose(rst_n) |-> refOutEnFf == 1'b0)
        else $error("reference pin not input after reset");
endmodule : dlc_monitor

bind dlc_top dlc_monitor u_dlc_monitor (.clock, .rst_n, .sclPin, .sdaIn, .sdaOut, .sdaOe, .load_strobe_n,
    .async_clear_n, .addr_select_pin, .dacCode, .inputCode, .pendingFf, .clrCodeFf, .refOutEnFf);

// ---- tb/dlc_host_model.sv ----
// Two-wire bus controller model that writes 32-bit words to the device.
// Assumes a pull-up on the data line; the model only ever pulls it low.
`timescale 1ns/1ps
module dlc_host_model (
    input wire logic clock,
    input wire logic sdaWire,
    output logic sclPin,
    output logic sdaLow
);
    // Bus clock stands high and data is released outside frames.
    initial
    begin
        sclPin = 1'b1;
        sdaLow = 1'b0;
    end
    // A quarter of the 160 ns bus clock period.
    task automatic quarter;
        repeat (8) @(posedge clock);
    endtask : quarter
    // Data changes only while the clock is low; the wire is sampled mid-high.
    task automatic put_bit(input logic b, output logic seen);
        sdaLow <= ~b;
        quarter();
        sclPin <= 1'b1;
        quarter();
        seen = sdaWire;
        quarter();
        sclPin <= 1'b0;
        quarter();
    endtask : put_bit
    // Start, four bytes MSB first each with an acknowledge slot, then stop.
    task automatic send_word(input logic [31:0] word, output logic [3:0] acks);
        logic seen;
        sdaLow <= 1'b1;
        quarter();
        sclPin <= 1'b0;
        quarter();
        for (int i = 31; i >= 0; i--)
        begin
            put_bit(word[i], seen);
            if (i % 8 == 0)
            begin
                put_bit(1'b1, seen);
                acks[i / 8] = ~seen;
            end
        end
        sdaLow <= 1'b1;
        quarter();
        sclPin <= 1'b1;
        quarter();
        sdaLow <= 1'b0;
        quarter();
    endtask : send_word
endmodule : dlc_host_model

// ---- tb/dlc_top_tb.sv ----
// Self-checking bench: table of serial writes, then load, clear, address and reset cases.
// Assumes the design files and the bus model are compiled before this file.
`timescale 1ns/1ps
module dlc_top_tb;
    typedef struct packed {logic [3:0] cmd; logic [3:0] chan; logic [15:0] code; logic [2:0] chk;
        logic [15:0] expIn; logic [15:0] expDac; logic [1:0] expClr; logic expRef;} dlc_row_t;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic ldN = 1'b1;
    logic clrN = 1'b1;
    logic addrPin = 1'b0;
    logic sclPin, sdaLow, sdaOut, sdaOe, refOutEnFf;
    logic [7:0][15:0] dacCode, inputCode;
    logic [7:0] pendingFf;
    logic [1:0] clrCodeFf;
    logic [3:0] acks;
    int n_fail = 0;
    int n_tests = 0;
    // Pull-up wins unless a party pulls low.
    wire sdaWire = (sdaOe ? sdaOut : 1'b1) & ~sdaLow;
    dlc_row_t rows [6] = '{'{4'h0, 4'h2, 16'h1234, 3'h2, 16'h1234, 16'h0000, 2'h0, 1'b0},
        '{4'h3, 4'h7, 16'h5a5a, 3'h7, 16'h5a5a, 16'h5a5a, 2'h0, 1'b0},
        '{4'h1, 4'h2, 16'h0000, 3'h2, 16'h1234, 16'h1234, 2'h0, 1'b0},
        '{4'h0, 4'hf, 16'h0777, 3'h0, 16'h0777, 16'h0000, 2'h0, 1'b0},
        '{4'h8, 4'h0, 16'h0001, 3'h7, 16'h0777, 16'h5a5a, 2'h0, 1'b1},
        '{4'h8, 4'h0, 16'h0000, 3'h7, 16'h0777, 16'h5a5a, 2'h0, 1'b0}};
    logic [15:0] clrExp [3] = '{dlc_pkg::CODE_ZERO, dlc_pkg::CODE_MID, dlc_pkg::CODE_FULL};
    dlc_top u_dlc_top (.clock, .rst_n, .sclPin, .sdaIn(sdaWire), .sdaOut, .sdaOe, .load_strobe_n(ldN),
        .async_clear_n(clrN), .addr_select_pin(addrPin), .dacCode, .inputCode, .pendingFf, .clrCodeFf, .refOutEnFf);
    dlc_host_model u_dlc_host_model (.clock, .sdaWire, .sclPin, .sdaLow);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc
    // One frame, then a 200 ns gap, shorter than the 300 ns write-to-load spacing.
    task automatic send(input logic a0, input logic [3:0] c, input logic [3:0] ch, input logic [15:0] d,
        input logic [3:0] expAck);
        u_dlc_host_model.send_word({dlc_pkg::SLAVE_ADDR_HI, a0, 1'b0, c, ch, d}, acks);
        cyc(40);
        check({12'h0, acks}, {12'h0, expAck});
    endtask : send
    // Pin pulses of 30 ns, above both minimum widths.
    task automatic pulse(input logic isClr);
        if (isClr) clrN <= 1'b0; else ldN <= 1'b0;
        cyc(6);
        if (isClr) clrN <= 1'b1; else ldN <= 1'b1;
        cyc(6);
    endtask : pulse
    // Clock of 5 ns period.
    initial
    begin
        forever #2.5 clock = ~clock;
    end
    // Bound on the whole run.
    initial
    begin
        cyc(60000);
        n_fail++;
        wrap_up();
    end
    // Main sequence.
    initial
    begin
        cyc(20);
        rst_n <= 1'b1;
        cyc(2);
        check({14'h0, clrCodeFf}, 16'h0);
        check({15'h0, refOutEnFf}, 16'h0);
        foreach (rows[i])
        begin
            send(1'b0, rows[i].cmd, rows[i].chan, rows[i].code, 4'hf);
            check(inputCode[rows[i].chk], rows[i].expIn);
            check(dacCode[rows[i].chk], rows[i].expDac);
            check({13'h0, refOutEnFf, clrCodeFf}, {13'h0, rows[i].expRef, rows[i].expClr});
        end
        pulse(1'b0);
        for (int c = 0; c < 8; c++)
            check(dacCode[c], 16'h0777);
        // Clear-code settings 0 to 2, with a write still pending at the clear.
        for (int k = 0; k < 3; k++)
        begin
            send(1'b0, dlc_pkg::CMD_CLR_CODE, 4'h0, 16'(k), 4'hf);
            send(1'b0, dlc_pkg::CMD_WRITE_IN, 4'h1, 16'h1111, 4'hf);
            pulse(1'b1);
            check(inputCode[1], clrExp[k]);
            check(dacCode[5], clrExp[k]);
            check({8'h0, pendingFf}, 16'h0);
        end
        clrN <= 1'b0;
        cyc(10);
        send(1'b0, dlc_pkg::CMD_WRITE_IN, 4'h3, 16'h2222, 4'hf);
        pulse(1'b0);
        clrN <= 1'b1;
        cyc(10);
        check(dacCode[3], clrExp[2]);
        ldN <= 1'b0;
        cyc(10);
        send(1'b0, dlc_pkg::CMD_WRITE_IN, 4'h4, 16'h4444, 4'hf);
        check(dacCode[4], 16'h4444);
        ldN <= 1'b1;
        addrPin <= 1'b1;
        cyc(10);
        send(1'b0, dlc_pkg::CMD_REF_CTL, 4'h0, 16'h0001, 4'h0);
        send(1'b1, dlc_pkg::CMD_REF_CTL, 4'h0, 16'h0001, 4'hf);
        check({15'h0, refOutEnFf}, 16'h1);
        rst_n <= 1'b0;
        cyc(20);
        rst_n <= 1'b1;
        cyc(2);
        check({13'h0, refOutEnFf, clrCodeFf}, 16'h0);
        wrap_up();
    end
endmodule : dlc_top_tb
